// ---- tdde_consts.svh ----
// constants for the transmit descriptor dma engine
`ifndef TDDE_CONSTS_SVH
`define TDDE_CONSTS_SVH

// transmit data fifo capacity in bytes (plain default)
`define TDDE_FIFO_CAP 12'h800
// descriptor field offsets from the descriptor pointer
`define TDDE_LINK_OFS 32'h0000_0000
`define TDDE_STS_HI_OFS 32'h0000_0006
// lengths of the link refresh read and the status write-back
`define TDDE_LINK_LEN 12'h004
`define TDDE_STS_LEN 12'h002
// command/status word field positions
`define TDDE_OWN_BIT 31
`define TDDE_MORE_BIT 30
`define TDDE_SIZE_MSB 11
// own bit inside the upper half-word
`define TDDE_OWN_HI_BIT 15
// reset values
`define TDDE_ADDR_RST 32'h0000_0000
`define TDDE_CNT_RST 12'h000

`endif

// ---- tdde_pkg.sv ----
// types shared by the transmit descriptor dma engine
package tdde_pkg;

    typedef logic [31:0] tdde_addr_t;
    typedef logic [11:0] tdde_cnt_t;

    // gray codes along idle, fetch, wait, read, write, follow, refresh
    typedef enum logic [2:0] {
        xmit_state_idle = 3'h0,
        state_fetch_descriptor = 3'h1,
        state_wait_space = 3'h3,
        state_read_fragment = 3'h2,
        state_write_status = 3'h6,
        state_follow_link = 3'h7,
        state_link_refresh = 3'h5
    } tdde_state_t;

    typedef enum logic [1:0] {
        tdde_req_desc = 2'h0,
        tdde_req_link = 2'h1,
        tdde_req_frag = 2'h2,
        tdde_req_status = 2'h3
    } tdde_req_t;

endpackage

// ---- tdde_fifo_if.sv ----
// fifo level signals between the engine and its space monitor
`timescale 1ns/100ps
interface tdde_fifo_if;
    import tdde_pkg::*;

    tdde_cnt_t fill_level;
    tdde_cnt_t refill_level;
    tdde_cnt_t free_space;
    logic space_ready;

    modport eng (output fill_level, output refill_level, input free_space, input space_ready);
    modport mon (input fill_level, input refill_level, output free_space, output space_ready);
endinterface

// ---- tdde_space_mon.sv ----
// free space and space-ready tracking for the transmit data fifo
`timescale 1ns/100ps
`include "tdde_consts.svh"
module tdde_space_mon
    import tdde_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // fifo levels
    tdde_fifo_if.mon fif
);

    tdde_cnt_t free_ff;
    logic ready_ff;
    tdde_cnt_t nxt_free;

    // fill level never exceeds capacity, so the difference cannot wrap
    assign nxt_free = `TDDE_FIFO_CAP - fif.fill_level; // R17

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            free_ff <= `TDDE_CNT_RST;
            ready_ff <= 1'b0;
        end else begin
            free_ff <= nxt_free; // R17
            ready_ff <= (nxt_free > fif.refill_level); // R07
        end
    end

    assign fif.free_space = free_ff;
    assign fif.space_ready = ready_ff;

endmodule // tdde_space_mon

// ---- tdde_engine.sv ----
// transmit descriptor dma engine: list walker, fragment fetch, status write-back
// What this block does
// (R01) go while idle fetches current descriptor
// (R02) cache holds one fragment pointer and count
// (R03) idle, go, not done: fetch at pointer
// (R04) idle, go, done: refresh link field only
// (R05) link refresh complete moves to follow-link
// (R06) fetch done: owned waits, else idle event
// (R07) space ready only when free exceeds threshold
// (R08) read min of free and remaining, decrement
// (R09) empty with continuation: write status, clear own
// (R10) empty, last: push pointer handle, follow link
// (R11) fragment read complete returns to wait-space
// (R12) status write complete moves to follow-link
// (R13) non-null link: load pointer, clear done, fetch
// (R14) null link: done, idle event, clear go
// (R15) any pointer load clears done flag
// (R16) descriptor pointer is 32-bit host address
// (R17) free space equals capacity minus fill
// (R18) track remaining bytes and fragment cursor
// (R19) driver sets go to start or resume
// (R20) fragments may start and end anywhere
// (R21) status write-back moves only upper two bytes
// (R22) one transition per cycle, follow resolves once
`timescale 1ns/100ps
`include "tdde_consts.svh"
module tdde_engine
    import tdde_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // driver command and pointer writes
    input wire logic go_set,
    input wire tdde_addr_t ptr_wdata,
    input wire logic ptr_write,
    input wire logic idle_event_clear,
    // configuration
    input wire tdde_cnt_t xmit_config,
    input wire tdde_cnt_t refill_level,
    // status
    output logic transmit_go_bit,
    output logic desc_done_flag,
    output tdde_addr_t tx_desc_pointer,
    output logic xmit_idle_event,
    output tdde_state_t state,
    output tdde_cnt_t bytes_left,
    output tdde_addr_t fragment_cursor,
    output tdde_cnt_t fifo_free_space,
    // bus master request
    output logic bus_start,
    output tdde_req_t bus_kind,
    output tdde_addr_t bus_addr,
    output tdde_cnt_t bus_len,
    output logic [15:0] bus_wdata,
    // bus master answer
    input wire logic transfer_complete,
    input wire tdde_addr_t rd_link,
    input wire logic [31:0] rd_cmdsts,
    input wire tdde_addr_t rd_frag_ptr,
    // transmit data fifo
    input wire tdde_cnt_t fifo_fill_level,
    output logic handle_valid,
    output tdde_addr_t handle_data
);

    tdde_fifo_if fif ();

    tdde_space_mon u_mon (
        .mclk(mclk),
        .reset(reset),
        .fif(fif)
    );

    assign fif.fill_level = fifo_fill_level;
    assign fif.refill_level = refill_level;

    tdde_state_t state_ff;
    tdde_state_t nxt_state;
    logic go_ff;
    logic done_ff;
    logic idle_evt_ff;
    tdde_addr_t ptr_ff;
    // one-entry descriptor cache
    tdde_addr_t link_ff;
    tdde_addr_t cursor_ff;
    tdde_cnt_t left_ff;
    logic [15:0] sts_hi_ff;
    logic start_ff;
    tdde_req_t kind_ff;
    tdde_addr_t addr_ff;
    tdde_cnt_t len_ff;
    logic [15:0] wdata_ff;
    logic hvalid_ff;
    tdde_addr_t hdata_ff;
    tdde_cnt_t free_ff;

    // decoded events of the current state
    logic ev_fetch;
    logic ev_refresh;
    logic ev_desc_done;
    logic ev_owned;
    logic ev_frag;
    logic ev_status;
    logic ev_handle;
    logic ev_follow;
    logic ev_null;
    logic ev_idle_set;
    tdde_cnt_t burst_len;

    function automatic tdde_cnt_t min_cnt(input tdde_cnt_t a, input tdde_cnt_t b);
        min_cnt = (a < b) ? a : b;
    endfunction

    function automatic logic is_state(input tdde_state_t cur, input tdde_state_t want);
        is_state = (cur == want);
    endfunction

    always_comb begin
        ev_fetch = is_state(state_ff, xmit_state_idle) && go_ff && !done_ff; // R03
        ev_refresh = is_state(state_ff, xmit_state_idle) && go_ff && done_ff; // R04
        ev_desc_done = is_state(state_ff, state_fetch_descriptor) && transfer_complete;
        ev_owned = ev_desc_done && rd_cmdsts[`TDDE_OWN_BIT]; // R06
        ev_status = is_state(state_ff, state_wait_space) && (left_ff == `TDDE_CNT_RST)
            && sts_hi_ff[`TDDE_MORE_BIT - 16]; // R09
        ev_handle = is_state(state_ff, state_wait_space) && (left_ff == `TDDE_CNT_RST)
            && !sts_hi_ff[`TDDE_MORE_BIT - 16]; // R10
        // empty descriptors take priority so a zero-length burst is never issued
        ev_frag = is_state(state_ff, state_wait_space) && (left_ff != `TDDE_CNT_RST)
            && fif.space_ready; // R08
        ev_follow = is_state(state_ff, state_follow_link) && (link_ff != `TDDE_ADDR_RST); // R13
        ev_null = is_state(state_ff, state_follow_link) && (link_ff == `TDDE_ADDR_RST); // R14
        ev_idle_set = (ev_desc_done && !ev_owned) || ev_null; // R06 R14
        burst_len = min_cnt(fif.free_space, left_ff); // R08
    end

    // one next state per cycle; follow-link never waits
    always_comb begin
        nxt_state = state_ff; // R22
        unique case (state_ff)
            xmit_state_idle: begin
                if (ev_fetch) begin
                    nxt_state = state_fetch_descriptor; // R01 R03
                end else if (ev_refresh) begin
                    nxt_state = state_link_refresh; // R04
                end
            end
            state_link_refresh: begin
                if (transfer_complete) begin
                    nxt_state = state_follow_link; // R05
                end
            end
            state_fetch_descriptor: begin
                if (ev_desc_done) begin
                    nxt_state = ev_owned ? state_wait_space : xmit_state_idle; // R06
                end
            end
            state_wait_space: begin
                if (ev_status) begin
                    nxt_state = state_write_status; // R09
                end else if (ev_handle) begin
                    nxt_state = state_follow_link; // R10
                end else if (ev_frag) begin
                    nxt_state = state_read_fragment; // R08
                end
            end
            state_read_fragment: begin
                if (transfer_complete) begin
                    nxt_state = state_wait_space; // R11
                end
            end
            state_write_status: begin
                if (transfer_complete) begin
                    nxt_state = state_follow_link; // R12
                end
            end
            state_follow_link: begin
                nxt_state = ev_follow ? state_fetch_descriptor : xmit_state_idle; // R13 R14 R22
            end
            // the one unused code falls back to idle rather than locking up
            default: begin
                nxt_state = xmit_state_idle;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff <= xmit_state_idle;
        end else begin
            state_ff <= nxt_state; // R22
        end
    end

    // go bit: a driver set in the same cycle as the clear wins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            go_ff <= 1'b0;
        end else if (go_set) begin
            go_ff <= 1'b1; // R01 R19
        end else if (ev_null) begin
            go_ff <= 1'b0; // R14
        end
    end

    // pointer: the engine's own load beats a driver write in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ptr_ff <= `TDDE_ADDR_RST;
        end else if (ev_follow) begin
            ptr_ff <= link_ff; // R13 R16
        end else if (ptr_write) begin
            ptr_ff <= ptr_wdata; // R16
        end
    end

    // done flag: any pointer load clears it, since the flag describes the old pointer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else if (ev_follow || ptr_write) begin
            done_ff <= 1'b0; // R13 R15
        end else if (ev_null) begin
            done_ff <= 1'b1; // R14
        end
    end

    // sticky idle event; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idle_evt_ff <= 1'b0;
        end else if (ev_idle_set) begin
            idle_evt_ff <= 1'b1; // R06 R14
        end else if (idle_event_clear) begin
            idle_evt_ff <= 1'b0;
        end
    end

    // descriptor cache holds a single pointer/count pair and the link
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_ff <= `TDDE_ADDR_RST;
            cursor_ff <= `TDDE_ADDR_RST;
            left_ff <= `TDDE_CNT_RST;
            sts_hi_ff <= 16'h0000;
        end else if (ev_desc_done) begin
            link_ff <= rd_link; // R02
            cursor_ff <= rd_frag_ptr; // R02 R20
            left_ff <= rd_cmdsts[`TDDE_SIZE_MSB:0]; // R02
            sts_hi_ff <= rd_cmdsts[31:16];
        end else if (is_state(state_ff, state_link_refresh) && transfer_complete) begin
            link_ff <= rd_link; // R04 R05
        end else if (ev_frag) begin
            // byte granular: no rounding of cursor or length
            cursor_ff <= cursor_ff + {20'h00000, burst_len}; // R18 R20
            left_ff <= left_ff - burst_len; // R08 R18
        end
    end

    // bus request: one-cycle start with attributes held until the next start
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            start_ff <= 1'b0;
            kind_ff <= tdde_req_desc;
            addr_ff <= `TDDE_ADDR_RST;
            len_ff <= `TDDE_CNT_RST;
            wdata_ff <= 16'h0000;
        end else begin
            start_ff <= ev_fetch || ev_refresh || ev_frag || ev_status || ev_follow;
            if (ev_fetch) begin
                kind_ff <= tdde_req_desc;
                addr_ff <= ptr_ff; // R03
                len_ff <= xmit_config; // R03
            end else if (ev_follow) begin
                kind_ff <= tdde_req_desc;
                addr_ff <= link_ff; // R13
                len_ff <= xmit_config; // R13
            end else if (ev_refresh) begin
                kind_ff <= tdde_req_link;
                addr_ff <= ptr_ff + `TDDE_LINK_OFS; // R04
                len_ff <= `TDDE_LINK_LEN; // R04
            end else if (ev_frag) begin
                kind_ff <= tdde_req_frag;
                addr_ff <= cursor_ff; // R08 R20
                len_ff <= burst_len; // R08
            end else if (ev_status) begin
                kind_ff <= tdde_req_status;
                addr_ff <= ptr_ff + `TDDE_STS_HI_OFS; // R21
                len_ff <= `TDDE_STS_LEN; // R21
                wdata_ff <= sts_hi_ff & ~(16'h0001 << `TDDE_OWN_HI_BIT); // R09 R21
            end
        end
    end

    // packet handle pushed into the data fifo
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hvalid_ff <= 1'b0;
            hdata_ff <= `TDDE_ADDR_RST;
        end else begin
            hvalid_ff <= ev_handle; // R10
            if (ev_handle) begin
                hdata_ff <= ptr_ff; // R10
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            free_ff <= `TDDE_CNT_RST;
        end else begin
            free_ff <= fif.free_space; // R17
        end
    end

    assign transmit_go_bit = go_ff;
    assign desc_done_flag = done_ff;
    assign tx_desc_pointer = ptr_ff;
    assign xmit_idle_event = idle_evt_ff;
    assign state = state_ff;
    assign bytes_left = left_ff;
    assign fragment_cursor = cursor_ff;
    assign fifo_free_space = free_ff;
    assign bus_start = start_ff;
    assign bus_kind = kind_ff;
    assign bus_addr = addr_ff;
    assign bus_len = len_ff;
    assign bus_wdata = wdata_ff;
    assign handle_valid = hvalid_ff;
    assign handle_data = hdata_ff;

endmodule // tdde_engine

// ---- tdde_engine_props.sv ----
// port-level assertions for the transmit descriptor dma engine
`timescale 1ns/100ps
module tdde_engine_props
    import tdde_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // configuration
    input wire tdde_cnt_t xmit_config,
    input wire tdde_cnt_t refill_level,
    // engine status
    input wire logic transmit_go_bit,
    input wire logic desc_done_flag,
    input wire tdde_addr_t tx_desc_pointer,
    input wire logic xmit_idle_event,
    input wire tdde_state_t state,
    input wire tdde_cnt_t bytes_left,
    input wire tdde_addr_t fragment_cursor,
    input wire tdde_cnt_t fifo_free_space,
    // bus master
    input wire logic bus_start,
    input wire tdde_req_t bus_kind,
    input wire tdde_addr_t bus_addr,
    input wire tdde_cnt_t bus_len,
    input wire logic [15:0] bus_wdata,
    input wire logic transfer_complete,
    input wire logic [31:0] rd_cmdsts
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_idle_fetch;
        state == xmit_state_idle && transmit_go_bit && !desc_done_flag |=> bus_start
            && bus_kind == tdde_req_desc && state == state_fetch_descriptor
            && bus_addr == $past(tx_desc_pointer) && bus_len == $past(xmit_config);
    endproperty
    a_idle_fetch: assert property (p_idle_fetch) else $error("no fetch");
    property p_idle_refresh;
        state == xmit_state_idle && transmit_go_bit && desc_done_flag |=> bus_start
            && bus_kind == tdde_req_link && state == state_link_refresh
            && bus_addr == $past(tx_desc_pointer) && bus_len == 12'h004;
    endproperty
    a_idle_refresh: assert property (p_idle_refresh) else $error("no refresh");
    property p_to_follow;
        (state == state_link_refresh || state == state_write_status) && transfer_complete
            |=> state == state_follow_link;
    endproperty
    a_to_follow: assert property (p_to_follow) else $error("no follow");
    property p_fetch_end;
        state == state_fetch_descriptor && transfer_complete && rd_cmdsts[31]
            |=> state == state_wait_space && bytes_left == tdde_cnt_t'($past(rd_cmdsts));
    endproperty
    a_fetch_end: assert property (p_fetch_end) else $error("fetch end");
    property p_frag_start;
        bus_start && bus_kind == tdde_req_frag |-> state == state_read_fragment
            && fifo_free_space > refill_level && fragment_cursor == bus_addr + 32'(bus_len)
            && bus_len == ($past(bytes_left) < fifo_free_space ? $past(bytes_left)
            : fifo_free_space) && bytes_left == $past(bytes_left) - bus_len;
    endproperty
    a_frag_start: assert property (p_frag_start) else $error("frag burst");
    property p_frag_end;
        state == state_read_fragment && transfer_complete |=> state == state_wait_space;
    endproperty
    a_frag_end: assert property (p_frag_end) else $error("frag end");
    property p_status;
        bus_start && bus_kind == tdde_req_status |-> state == state_write_status
            && bus_len == 12'h002 && bus_addr == tx_desc_pointer + 32'h0000_0006
            && !bus_wdata[15] && bytes_left == 12'h000;
    endproperty
    a_status: assert property (p_status) else $error("status write");
    property p_follow_once;
        state == state_follow_link |=> state inside {state_fetch_descriptor, xmit_state_idle};
    endproperty
    a_follow_once: assert property (p_follow_once) else $error("follow stuck");
    property p_null_link;
        $past(state) == state_follow_link && state == xmit_state_idle
            |-> desc_done_flag && xmit_idle_event && !transmit_go_bit;
    endproperty
    a_null_link: assert property (p_null_link) else $error("null link");
endmodule // tdde_engine_props

bind tdde_engine tdde_engine_props u_props (.mclk, .reset, .xmit_config, .refill_level,
    .transmit_go_bit, .desc_done_flag, .tx_desc_pointer, .xmit_idle_event, .state,
    .bytes_left, .fragment_cursor, .fifo_free_space, .bus_start, .bus_kind, .bus_addr,
    .bus_len, .bus_wdata, .transfer_complete, .rd_cmdsts);

// ---- tdde_host_mem.sv ----
// host memory model answering the engine's bus-master bursts
`timescale 1ns/100ps
module tdde_host_mem
    import tdde_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // request and test controls
    input wire logic bus_start,
    input wire tdde_addr_t bus_addr,
    input wire tdde_addr_t tail_link,
    input wire logic slow,
    // answer
    output logic transfer_complete,
    output tdde_addr_t rd_link,
    output logic [31:0] rd_cmdsts,
    output tdde_addr_t rd_frag_ptr
);
    tdde_addr_t addr_ff;
    logic busy_ff;
    logic [3:0] wait_ff;
    logic [95:0] word;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            busy_ff <= 1'b0;
            wait_ff <= 4'h0;
            addr_ff <= 32'h0000_0000;
            transfer_complete <= 1'b0;
        end else begin
            transfer_complete <= 1'b0;
            if (bus_start) begin
                busy_ff <= 1'b1;
                wait_ff <= slow ? 4'h6 : 4'h0;
                addr_ff <= bus_addr;
            end else if (busy_ff && wait_ff == 4'h0) begin
                busy_ff <= 1'b0;
                transfer_complete <= 1'b1;
            end else if (busy_ff) begin
                wait_ff <= wait_ff - 4'h1;
            end
        end
    end

    // link, cmdsts, fragment pointer; unknown places hold a descriptor the driver still owns
    always_comb begin
        case (addr_ff[11:8])
            4'h1: word = {32'h0000_0200, 32'hc000_000a, 32'h0000_1003};
            4'h2: word = {tail_link, 32'h8000_0005, 32'h0000_2001};
            4'h3: word = {32'h0000_0000, 32'h8000_0000, 32'h0000_0000};
            default: word = {32'h0000_0000, 32'h0000_0007, 32'h0000_0000};
        endcase
    end
    // off the completion cycle the bus shows junk, so a late sample cannot pass by luck
    assign {rd_link, rd_cmdsts, rd_frag_ptr} = transfer_complete ? word : ~word;
endmodule // tdde_host_mem

// ---- tb.sv ----
// self-checking bench for the transmit descriptor dma engine
`timescale 1ns/100ps
`include "tdde_consts.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("FAIL %s expected %h seen %h", n, e, a); end end
module tb
    import tdde_pkg::*;
;
    typedef struct {tdde_req_t k; tdde_addr_t a; tdde_cnt_t l;
        tdde_cnt_t fill; tdde_cnt_t thr;} tdde_row_t;
    logic mclk, reset, go_set, ptr_write, idle_event_clear, slow, transfer_complete;
    logic transmit_go_bit, desc_done_flag, xmit_idle_event, bus_start, handle_valid;
    tdde_addr_t ptr_wdata, tail_link, rd_link, rd_frag_ptr, tx_desc_pointer;
    tdde_addr_t fragment_cursor, bus_addr, handle_data;
    tdde_cnt_t xmit_config, refill_level, fifo_fill_level, bytes_left, fifo_free_space, bus_len;
    logic [31:0] rd_cmdsts;
    logic [15:0] bus_wdata;
    tdde_state_t state;
    tdde_req_t bus_kind;
    int n_fail, checks_done;
    tdde_row_t rows [6] = '{
        '{tdde_req_desc, 32'h0000_0100, 12'h010, 12'h000, 12'h010},
        '{tdde_req_frag, 32'h0000_1003, 12'h00a, 12'h000, 12'h010},
        '{tdde_req_status, 32'h0000_0106, 12'h002, 12'h000, 12'h010},
        '{tdde_req_desc, 32'h0000_0200, 12'h010, 12'h000, 12'h010},
        '{tdde_req_frag, 32'h0000_2001, 12'h003, 12'h7fd, 12'h002},
        '{tdde_req_frag, 32'h0000_2004, 12'h002, 12'h7fd, 12'h002}};

    tdde_engine dut (.mclk, .reset, .go_set, .ptr_wdata, .ptr_write, .idle_event_clear,
        .xmit_config, .refill_level, .transmit_go_bit, .desc_done_flag, .tx_desc_pointer,
        .xmit_idle_event, .state, .bytes_left, .fragment_cursor, .fifo_free_space, .bus_start,
        .bus_kind, .bus_addr, .bus_len, .bus_wdata, .transfer_complete, .rd_link, .rd_cmdsts,
        .rd_frag_ptr, .fifo_fill_level, .handle_valid, .handle_data);
    tdde_host_mem host (.mclk, .reset, .bus_start, .bus_addr, .tail_link, .slow,
        .transfer_complete, .rd_link, .rd_cmdsts, .rd_frag_ptr);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    // hnd selects the fifo handle push instead of a bus start
    task automatic wait_for(input bit hnd);
        int n;
        n = 0;
        @(negedge mclk);
        while ((hnd ? handle_valid : bus_start) !== 1'b1) begin
            n++;
            if (n > 200) begin
                n_fail++;
                test_done();
            end
            @(negedge mclk);
        end
    endtask

    initial begin
        reset = 1'b1;
        go_set = 1'b0;
        ptr_write = 1'b0;
        idle_event_clear = 1'b0;
        slow = 1'b1;
        ptr_wdata = 32'h0000_0100;
        tail_link = 32'h0000_0000;
        xmit_config = 12'h010;
        refill_level = 12'h010;
        fifo_fill_level = 12'h000;
        repeat (20) @(negedge mclk);
        `CHK("reset state", xmit_state_idle, state)
        `CHK("reset start", 1'b0, bus_start)
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        pulse(ptr_write);
        `CHK("pointer", 32'h0000_0100, tx_desc_pointer)
        pulse(go_set);
        foreach (rows[i]) begin
            // free space equal to the threshold must hold the engine off the fragment
            if (i == 4) begin
                fifo_fill_level = 12'h7fe;
                refill_level = 12'h002;
                repeat (30) @(negedge mclk);
                `CHK("held at threshold", state_wait_space, state)
                `CHK("left", 12'h005, bytes_left)
                `CHK("free", `TDDE_FIFO_CAP - 12'h7fe, fifo_free_space)
            end
            fifo_fill_level = rows[i].fill;
            refill_level = rows[i].thr;
            wait_for(1'b0);
            `CHK("kind", rows[i].k, bus_kind)
            `CHK("addr", rows[i].a, bus_addr)
            `CHK("len", rows[i].l, bus_len)
            if (rows[i].k == tdde_req_status) `CHK("wdata", 16'h4000, bus_wdata)
            `CHK("free", `TDDE_FIFO_CAP - rows[i].fill, fifo_free_space)
            if (rows[i].k == tdde_req_frag) begin
                `CHK("cursor", rows[i].a + 32'(rows[i].l), fragment_cursor)
            end
        end
        wait_for(1'b1);
        `CHK("handle", 32'h0000_0200, handle_data)
        repeat (2) @(negedge mclk);
        `CHK("state", xmit_state_idle, state)
        `CHK("done", 1'b1, desc_done_flag)
        `CHK("go", 1'b0, transmit_go_bit)
        `CHK("idle event", 1'b1, xmit_idle_event)
        pulse(idle_event_clear);
        `CHK("idle event", 1'b0, xmit_idle_event)
        // appended tail: resume must refresh the link, not refetch
        tail_link = 32'h0000_0300;
        slow = 1'b0;
        pulse(go_set);
        wait_for(1'b0);
        `CHK("kind", tdde_req_link, bus_kind)
        `CHK("addr", 32'h0000_0200, bus_addr)
        wait_for(1'b0);
        `CHK("kind", tdde_req_desc, bus_kind)
        `CHK("pointer", 32'h0000_0300, tx_desc_pointer)
        `CHK("done", 1'b0, desc_done_flag)
        wait_for(1'b1);
        `CHK("handle", 32'h0000_0300, handle_data)
        repeat (2) @(negedge mclk);
        `CHK("done", 1'b1, desc_done_flag)
        pulse(idle_event_clear);
        ptr_wdata = 32'h0000_0400;
        pulse(ptr_write);
        `CHK("done", 1'b0, desc_done_flag)
        pulse(go_set);
        wait_for(1'b0);
        `CHK("kind", tdde_req_desc, bus_kind)
        `CHK("addr", 32'h0000_0400, bus_addr)
        repeat (4) @(negedge mclk);
        `CHK("idle event", 1'b1, xmit_idle_event)
        test_done();
    end
endmodule // tb
